// ---- rtl/ped_pkg.sv ----
package ped_pkg;

  // Clock and time base
  localparam int CLK_PERIOD_NS = 100;
  localparam int MS_NS         = 1_000_000;
  localparam int MS_CYCLES     = MS_NS / CLK_PERIOD_NS;

  // Event numbering
  localparam int          NUM_EVT  = 34;
  localparam int          EVT_W    = 6;
  localparam logic [5:0]  EVT_LIMIT = 6'h22;
  localparam logic [33:0] COMM_MASK  = 34'h0_0780_0300;
  localparam logic [33:0] TIMED_MASK = 34'h0_0060_0C00;
  localparam logic [5:0]  EVT_TIMED0 = 6'h0A;
  localparam logic [5:0]  EVT_TIMED1 = 6'h0B;

  // Groups, highest priority first
  localparam int GRP_COMM  = 0;
  localparam int GRP_IO    = 1;
  localparam int GRP_TIMED = 2;
  localparam int NUM_GRP   = 3;
  localparam int QMAX      = 16;
  localparam int CNT_W     = 5;
  localparam logic [2:0][4:0] QDEPTH = {5'h08, 5'h10, 5'h08};
  localparam logic [2:0][4:0] GRP_LEN = {5'h04, 5'h18, 5'h06};

  // Order inside each group, entry 0 is served first
  localparam logic [23:0][5:0] ORD_COMM = {108'h0, 6'h1A, 6'h19, 6'h18, 6'h17, 6'h09, 6'h08};
  localparam logic [23:0][5:0] ORD_IO = {6'h21, 6'h1F, 6'h1E, 6'h1D, 6'h20, 6'h12, 6'h11,
    6'h10, 6'h0F, 6'h0E, 6'h0D, 6'h1C, 6'h1B, 6'h0C, 6'h07, 6'h05, 6'h03, 6'h01, 6'h06,
    6'h04, 6'h02, 6'h00, 6'h14, 6'h13};
  localparam logic [23:0][5:0] ORD_TIMED = {120'h0, 6'h16, 6'h15, 6'h0B, 6'h0A};

  // Register map (byte addresses)
  localparam logic [7:0] REG_CTRL    = 8'h00;
  localparam logic [7:0] REG_STATUS  = 8'h04;
  localparam logic [7:0] REG_ATTACH  = 8'h08;
  localparam logic [7:0] REG_PER0    = 8'h0C;
  localparam logic [7:0] REG_PER1    = 8'h10;
  localparam logic [7:0] REG_ATT_LO  = 8'h14;
  localparam logic [7:0] REG_ATT_HI  = 8'h18;

  // Field positions
  localparam int CTRL_RUN_BIT   = 0;
  localparam int ATT_SET_BIT    = 8;
  localparam int ST_GEN_BIT     = 0;
  localparam int ST_ACT_BIT     = 1;
  localparam int ST_OVF_LSB     = 2;
  localparam int ST_INV_BIT     = 5;
  localparam int ST_DEPTH_BIT   = 6;
  localparam logic [7:0] PER_RESET = 8'h00;

  typedef struct packed {
    logic [31:0]      logic_stack;
    logic [3:0][31:0] acc;
    logic [15:0]      flags;
  } ped_ctx_type;

  typedef struct packed {
    logic [5:0] cv_eq;
    logic [5:0] dir_chg;
    logic [5:0] ext_rst;
    logic [1:0] pto_done;
    logic [1:0] rx_char;
    logic [1:0] tx_done;
    logic [1:0] rx_msg;
  } ped_src_type;

  typedef struct packed {
    logic op_disable;
    logic op_enable;
    logic op_counter_definition_op;
    logic op_end;
    logic handler_last;
    logic cond_return;
    logic cond_true;
    logic move_busy;
    logic sub_call;
    logic sub_return;
  } ped_core_type;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_ACTIVE = 2'b01
  } ped_state_type;

endpackage

// ---- rtl/ped_dispatch.sv ----
`timescale 1ns/1ps
`default_nettype none

module ped_dispatch #(
  parameter int MS_CYCLES = ped_pkg::MS_CYCLES
) (
  input  wire logic               clk,
  input  wire logic               reset,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic                    pready,
  output logic [31:0]             prdata,
  output logic                    pslverr,
  input  wire logic [3:0]         edge_input,
  input  wire ped_pkg::ped_src_type src_evt,
  input  wire logic [1:0][15:0]   mt_current,
  input  wire logic [1:0][15:0]   mt_preset,
  input  wire logic [1:0]         mt_delay_mode,
  input  wire ped_pkg::ped_core_type core,
  input  wire ped_pkg::ped_ctx_type  ctx_in,
  output logic                    handler_start,
  output logic [5:0]              handler_evt,
  output logic                    handler_active,
  output logic                    ctx_restore,
  output ped_pkg::ped_ctx_type    ctx_out,
  output logic                    invalid_op
);

  function automatic logic [6:0] pick_evt(input logic [33:0] v,
                                          input logic [23:0][5:0] ord,
                                          input logic [4:0] n);
    logic [6:0] r;
    r = 7'h00;
    for (int i = 23; i >= 0; i--)
    begin
      if ((5'(i) < n) && v[ord[i]])
        r = {1'b1, ord[i]};
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [1:0][3:0]  sync_reg;
  logic [3:0]       edge_prev_reg;
  logic [33:0]      attached_reg, pending_reg, pending_next;
  logic [1:0][7:0]  per_reg, per_live_reg;
  logic [1:0][7:0]  tcount_reg;
  logic [31:0]      tick_cnt_reg;
  logic [1:0]       mt_eq_reg;
  logic             run_reg, gen_reg, invalid_reg, depth_reg;
  logic [2:0]       ovf_reg;
  ped_pkg::ped_state_type state_reg;
  ped_pkg::ped_ctx_type   saved_reg;

  ////////////////////////////////////////////////////////////////////////////
  // APB decode
  wire        wr_en    = psel & penable & pready & pwrite;
  wire        setup    = psel & ~penable;
  wire        addr_ok  = (paddr <= ped_pkg::REG_ATT_HI) && (paddr[1:0] == 2'b00);
  wire        wr_ctrl  = wr_en & (paddr == ped_pkg::REG_CTRL);
  wire        wr_att   = wr_en & (paddr == ped_pkg::REG_ATTACH) & (pwdata[5:0] < ped_pkg::EVT_LIMIT);
  wire        wr_per0  = wr_en & (paddr == ped_pkg::REG_PER0);
  wire        wr_per1  = wr_en & (paddr == ped_pkg::REG_PER1);
  wire        wr_stat  = wr_en & (paddr == ped_pkg::REG_STATUS);
  wire [5:0]  att_evt  = pwdata[5:0];
  wire        att_set  = pwdata[ped_pkg::ATT_SET_BIT];
  wire        run_next = wr_ctrl ? pwdata[ped_pkg::CTRL_RUN_BIT] : run_reg;
  wire        run_exit = run_reg & ~run_next;

  wire [31:0] status_word = {25'h0, depth_reg, invalid_reg, ovf_reg, state_reg == ped_pkg::ST_ACTIVE,
                             gen_reg};
  wire [31:0] rd_word =
    (paddr == ped_pkg::REG_CTRL)   ? {31'h0, run_reg} :
    (paddr == ped_pkg::REG_STATUS) ? status_word :
    (paddr == ped_pkg::REG_PER0)   ? {24'h0, per_reg[0]} :
    (paddr == ped_pkg::REG_PER1)   ? {24'h0, per_reg[1]} :
    (paddr == ped_pkg::REG_ATT_LO) ? attached_reg[31:0] :
    (paddr == ped_pkg::REG_ATT_HI) ? {30'h0, attached_reg[33:32]} : 32'h0;

  // One wait-free access phase; read data latched in setup
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      pready  <= 1'b0;
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= setup;
      prdata  <= setup ? rd_word : prdata;
      pslverr <= setup & ~addr_ok;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Millisecond tick; parameter lets a bench shorten it
  wire ms_tick = (tick_cnt_reg == 32'(MS_CYCLES - 1));

  always_ff @(posedge clk)
  begin
    if (reset)
      tick_cnt_reg <= 32'h0;
    else
      tick_cnt_reg <= ms_tick ? 32'h0 : tick_cnt_reg + 32'h1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Raw events
  logic [3:0] edge_lvl;
  assign edge_lvl = {sync_reg[1][3], sync_reg[1][2], sync_reg[1][1], sync_reg[1][0]};
  wire [3:0] rise = edge_lvl & ~edge_prev_reg;
  wire [3:0] fall = ~edge_lvl & edge_prev_reg;
  wire [1:0] tmr_exp;
  wire [1:0] mt_eq_now;
  wire [1:0] mt_hit;
  logic [33:0] raw_evt;

  // Match only in on/off delay mode, on the ms update, at the edge of equality
  assign mt_eq_now = {mt_current[1] == mt_preset[1], mt_current[0] == mt_preset[0]};
  assign mt_hit    = mt_eq_now & ~mt_eq_reg & mt_delay_mode & {2{ms_tick}};

  // Periodic timers expire when count reaches latched period; zero never fires
  assign tmr_exp[0] = ms_tick & attached_reg[ped_pkg::EVT_TIMED0] & (per_live_reg[0] != 8'h00)
                      & (tcount_reg[0] + 8'h01 == per_live_reg[0]);
  assign tmr_exp[1] = ms_tick & attached_reg[ped_pkg::EVT_TIMED1] & (per_live_reg[1] != 8'h00)
                      & (tcount_reg[1] + 8'h01 == per_live_reg[1]);

  // Event number map
  assign raw_evt = {src_evt.cv_eq[5], src_evt.cv_eq[3], src_evt.ext_rst[4], src_evt.dir_chg[4],
                    src_evt.cv_eq[4], src_evt.ext_rst[0], src_evt.dir_chg[0],
                    src_evt.tx_done[1], src_evt.rx_char[1], src_evt.rx_msg[1],
                    src_evt.rx_msg[0], mt_hit, src_evt.pto_done,
                    src_evt.ext_rst[2], src_evt.dir_chg[2], src_evt.cv_eq[2],
                    src_evt.ext_rst[1], src_evt.dir_chg[1], src_evt.cv_eq[1],
                    src_evt.cv_eq[0], tmr_exp, src_evt.tx_done[0], src_evt.rx_char[0],
                    fall[3], rise[3], fall[2], rise[2], fall[1], rise[1], fall[0], rise[0]};

  // Input synchroniser and edge history; first stage read only by second
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      sync_reg      <= '0;
      edge_prev_reg <= 4'h0;
      mt_eq_reg     <= 2'b00;
    end
    else
    begin
      sync_reg[0]   <= edge_input;
      sync_reg[1]   <= sync_reg[0];
      edge_prev_reg <= edge_lvl;
      mt_eq_reg     <= ms_tick ? mt_eq_now : mt_eq_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Attach table and timed interrupt state
  wire att_t0 = wr_att & att_set & (att_evt == ped_pkg::EVT_TIMED0);
  wire att_t1 = wr_att & att_set & (att_evt == ped_pkg::EVT_TIMED1);

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      attached_reg <= 34'h0;
      per_reg      <= {2{ped_pkg::PER_RESET}};
      per_live_reg <= {2{ped_pkg::PER_RESET}};
      tcount_reg   <= '0;
      run_reg      <= 1'b0;
    end
    else
    begin
      run_reg <= run_next;
      if (wr_per0)
        per_reg[0] <= pwdata[7:0];
      if (wr_per1)
        per_reg[1] <= pwdata[7:0];
      if (wr_att)
        attached_reg[att_evt] <= att_set;
      if (run_exit)
      begin
        attached_reg[ped_pkg::EVT_TIMED0] <= 1'b0;
        attached_reg[ped_pkg::EVT_TIMED1] <= 1'b0;
      end
      // Attach latches period and clears elapsed time
      if (att_t0)
        per_live_reg[0] <= per_reg[0];
      if (att_t1)
        per_live_reg[1] <= per_reg[1];
      tcount_reg[0] <= (att_t0 | tmr_exp[0]) ? 8'h00 :
                       (ms_tick ? tcount_reg[0] + 8'h01 : tcount_reg[0]);
      tcount_reg[1] <= (att_t1 | tmr_exp[1]) ? 8'h00 :
                       (ms_tick ? tcount_reg[1] + 8'h01 : tcount_reg[1]);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pending latches feed one event per group per cycle into the queues
  logic [2:0]       q_push, q_pop, q_full, q_empty, q_ovf;
  logic [2:0][5:0]  q_push_evt, q_head;
  logic [2:0][6:0]  q_pick;

  assign q_pick[0] = pick_evt(pending_reg & ped_pkg::COMM_MASK, ped_pkg::ORD_COMM,
                              ped_pkg::GRP_LEN[0]);
  assign q_pick[1] = pick_evt(pending_reg & ~(ped_pkg::COMM_MASK | ped_pkg::TIMED_MASK),
                              ped_pkg::ORD_IO, ped_pkg::GRP_LEN[1]);
  assign q_pick[2] = pick_evt(pending_reg & ped_pkg::TIMED_MASK, ped_pkg::ORD_TIMED,
                              ped_pkg::GRP_LEN[2]);

  // Unattached events are ignored; new arrivals win over the clear
  always_comb
  begin
    pending_next = pending_reg;
    for (int g = 0; g < ped_pkg::NUM_GRP; g++)
    begin
      if (q_pick[g][6])
        pending_next[q_pick[g][5:0]] = 1'b0;
    end
    pending_next = (pending_next | (raw_evt & attached_reg)) & attached_reg;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      pending_reg <= 34'h0;
    else
      pending_reg <= pending_next;
  end

  // Per-group FIFOs; a full queue drops the event and flags overflow
  for (genvar g = 0; g < ped_pkg::NUM_GRP; g++)
  begin : g_q
    logic [5:0]             mem [ped_pkg::QMAX];
    logic [3:0]             head_reg, tail_reg;
    logic [ped_pkg::CNT_W-1:0] cnt_reg;
    assign q_push[g]     = q_pick[g][6] & ~q_full[g];
    assign q_ovf[g]      = q_pick[g][6] & q_full[g];
    assign q_push_evt[g] = q_pick[g][5:0];
    assign q_full[g]     = (cnt_reg == ped_pkg::QDEPTH[g]);
    assign q_empty[g]    = (cnt_reg == '0);
    assign q_head[g]     = mem[head_reg];
    always_ff @(posedge clk)
    begin
      if (reset)
      begin
        head_reg <= 4'h0;
        tail_reg <= 4'h0;
        cnt_reg  <= '0;
      end
      else
      begin
        if (q_push[g])
        begin
          mem[tail_reg] <= q_push_evt[g];
          tail_reg      <= (tail_reg == 4'(ped_pkg::QDEPTH[g] - 5'h01)) ? 4'h0 : tail_reg + 4'h1;
        end
        if (q_pop[g])
          head_reg <= (head_reg == 4'(ped_pkg::QDEPTH[g] - 5'h01)) ? 4'h0 : head_reg + 4'h1;
        cnt_reg <= cnt_reg + ped_pkg::CNT_W'(q_push[g]) - ped_pkg::CNT_W'(q_pop[g]);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Dispatcher
  wire in_handler = (state_reg == ped_pkg::ST_ACTIVE);
  wire any_ready  = ~&q_empty;
  wire can_start  = ~in_handler & gen_reg & ~core.move_busy & any_ready;
  wire handler_end = in_handler & (core.handler_last | (core.cond_return & core.cond_true));
  // A call from inside a subroutine would exceed the one allowed level
  wire bad_op     = in_handler & (core.op_disable | core.op_enable | core.op_counter_definition_op | core.op_end
                                  | (core.sub_call & depth_reg));

  // Comm first, then I/O, then timed
  assign q_pop[0] = can_start & ~q_empty[0];
  assign q_pop[1] = can_start & q_empty[0] & ~q_empty[1];
  assign q_pop[2] = can_start & q_empty[0] & q_empty[1];
  wire [5:0] start_evt = ~q_empty[0] ? q_head[0] : (~q_empty[1] ? q_head[1] : q_head[2]);

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state_reg      <= ped_pkg::ST_IDLE;
      gen_reg        <= 1'b0;
      handler_start  <= 1'b0;
      handler_evt    <= 6'h00;
      handler_active <= 1'b0;
      ctx_restore    <= 1'b0;
      ctx_out        <= '0;
      saved_reg      <= '0;
      depth_reg      <= 1'b0;
      invalid_reg    <= 1'b0;
      invalid_op     <= 1'b0;
      ovf_reg        <= 3'b000;
    end
    else
    begin
      handler_start <= can_start;
      ctx_restore   <= handler_end;
      // Global enable/disable honoured only outside a handler
      if (~in_handler & core.op_enable)
        gen_reg <= 1'b1;
      else if (~in_handler & core.op_disable)
        gen_reg <= 1'b0;
      // Set beats software clear of the sticky invalid flag
      invalid_reg <= bad_op | (invalid_reg & ~(wr_stat & pwdata[ped_pkg::ST_INV_BIT]));
      invalid_op  <= bad_op | (invalid_reg & ~(wr_stat & pwdata[ped_pkg::ST_INV_BIT]));
      if (can_start)
      begin
        state_reg      <= ped_pkg::ST_ACTIVE;
        handler_evt    <= start_evt;
        handler_active <= 1'b1;
        saved_reg      <= ctx_in;
      end
      else if (handler_end)
      begin
        state_reg      <= ped_pkg::ST_IDLE;
        handler_active <= 1'b0;
        ctx_out        <= saved_reg;
        depth_reg      <= 1'b0;
      end
      // One nesting level; a deeper call is flagged invalid above
      if (in_handler & core.sub_call)
        depth_reg <= 1'b1;
      else if (in_handler & core.sub_return)
        depth_reg <= 1'b0;
      // Overflow bits clear once queues drain and control returns
      ovf_reg <= q_ovf | ((handler_end & ~any_ready) ? 3'b000 : ovf_reg);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_no_start_disabled;
    @(posedge clk) disable iff (reset) handler_start |-> $past(gen_reg);
  endproperty
  a_no_start_disabled: assert property (p_no_start_disabled)
    else $error("handler started while globally disabled");

  property p_no_start_in_move;
    @(posedge clk) disable iff (reset) handler_start |-> !$past(core.move_busy);
  endproperty
  a_no_start_in_move: assert property (p_no_start_in_move)
    else $error("handler started during indivisible move");

  property p_end_restores;
    @(posedge clk) disable iff (reset) (handler_active && core.handler_last) |=> ctx_restore && !handler_active;
  endproperty
  a_end_restores: assert property (p_end_restores)
    else $error("handler end did not return to main program");

  property p_cond_return;
    @(posedge clk) disable iff (reset)
      (handler_active && core.cond_return && core.cond_true) |=> ctx_restore && !handler_active;
  endproperty
  a_cond_return: assert property (p_cond_return)
    else $error("conditional return did not end handler");

  property p_bad_op;
    @(posedge clk) disable iff (reset)
      (handler_active && core.op_disable) |=> invalid_op && $stable(gen_reg);
  endproperty
  a_bad_op: assert property (p_bad_op)
    else $error("forbidden op in handler not rejected");

  property p_ctx_save;
    @(posedge clk) disable iff (reset) handler_start |-> saved_reg == $past(ctx_in);
  endproperty
  a_ctx_save: assert property (p_ctx_save)
    else $error("context not saved on entry");

  property p_no_preempt;
    @(posedge clk) disable iff (reset) handler_active && !ctx_restore |=> !handler_start;
  endproperty
  a_no_preempt: assert property (p_no_preempt)
    else $error("handler pre-empted");

  property p_reattach;
    @(posedge clk) disable iff (reset) att_t0 |=> tcount_reg[0] == 8'h00 && per_live_reg[0] == $past(per_reg[0]);
  endproperty
  a_reattach: assert property (p_reattach)
    else $error("timed attach did not restart timing");

endmodule

`default_nettype wire

// ---- verification/ped_dispatch_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) \
  begin comparisons++; if ((got) !== (ex)) begin mismatches++; \
  $display("FAIL %s expected %h seen %h", nm, ex, got); end end
module testbench;
  localparam int         MS      = 10;
  localparam logic [9:0] OP_DIS  = 10'h200;
  localparam logic [9:0] OP_EN   = 10'h100;
  localparam logic [9:0] OP_LAST = 10'h020;
  localparam logic [9:0] OP_CRET = 10'h018;
  logic                  clk, reset, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]            paddr;
  logic [31:0]           pwdata, prdata, rdata;
  logic [3:0]            edge_input;
  logic [1:0][15:0]      mt_current, mt_preset;
  logic [1:0]            mt_delay_mode;
  logic [9:0]            lvl;
  logic [5:0]            handler_evt;
  logic                  handler_start, handler_active, ctx_restore, invalid_op;
  ped_pkg::ped_src_type  src_evt;
  ped_pkg::ped_core_type core;
  ped_pkg::ped_ctx_type  ctx_in, ctx_out;
  int                    mismatches = 0, comparisons = 0, cyc = 0, t0;
  logic [5:0]            att_q[7] = '{6'h00, 6'h01, 6'h08, 6'h09, 6'h0C, 6'h15, 6'h16};
  logic [5:0]            ord_q[3] = '{6'h08, 6'h09, 6'h0C};

  // Short millisecond so timed periods fit the run
  ped_dispatch #(.MS_CYCLES(MS)) dut_u (
    .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .edge_input(edge_input), .src_evt(src_evt), .mt_current(mt_current),
    .mt_preset(mt_preset), .mt_delay_mode(mt_delay_mode), .core(core), .ctx_in(ctx_in),
    .handler_start(handler_start), .handler_evt(handler_evt),
    .handler_active(handler_active), .ctx_restore(ctx_restore), .ctx_out(ctx_out),
    .invalid_op(invalid_op));

  // Clock, and a cycle count for period measurement
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // A bounded wait ran out: count it and stop
  task automatic bail();
    mismatches++;
    $display("FAIL wait expected 1 seen 0");
    print_verdict();
  endtask

  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    for (n = 0; n < 20 && pready !== 1'b1; n++) @(posedge clk);
    if (pready !== 1'b1) bail();
    rdata = prdata;
    err   = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ex);
    apb(1'b0, a, 32'h0000_0000);
    `CHK("pslverr", 1'b0, err)
    `CHK("rdata", ex, rdata)
  endtask

  // Core op pulse on top of the held level bits
  task automatic cop(input logic [9:0] v);
    @(posedge clk);
    core <= ped_pkg::ped_core_type'(v | lvl);
    @(posedge clk);
    core <= ped_pkg::ped_core_type'(lvl);
  endtask

  task automatic spulse(input logic [25:0] v);
    @(posedge clk);
    src_evt <= ped_pkg::ped_src_type'(v);
    @(posedge clk);
    src_evt <= '0;
  endtask

  // Dispatch (0) or reload (1); the current edge counts, as both may share one
  task automatic wait_hi(input bit sel);
    int n;
    for (n = 0; n < 80 && (sel ? ctx_restore : handler_start) !== 1'b1; n++) @(posedge clk);
    if ((sel ? ctx_restore : handler_start) !== 1'b1) bail();
  endtask

  task automatic fin(input logic [9:0] op);
    cop(op);
    wait_hi(1'b1);
    `CHK("active", 1'b0, handler_active)
  endtask

  task automatic no_start(input int n);
    repeat (n)
    begin
      @(posedge clk);
      `CHK("start", 1'b0, handler_start)
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {psel, penable, pwrite, reset} = 4'b0001;
    {paddr, pwdata, edge_input, mt_current, mt_preset, mt_delay_mode, lvl} = '0;
    {src_evt, core, ctx_in} = '0;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    rd(ped_pkg::REG_STATUS, 32'h0000_0000);
    rd(ped_pkg::REG_PER0, 32'h0000_0000);
    apb(1'b0, 8'h1C, 32'h0000_0000);
    `CHK("pslverr", 1'b1, err)
    apb(1'b1, ped_pkg::REG_PER1, 32'h0000_00FF);
    rd(ped_pkg::REG_PER1, 32'h0000_00FF);
    apb(1'b1, ped_pkg::REG_CTRL, 32'h0000_0001);
    foreach (att_q[i]) apb(1'b1, ped_pkg::REG_ATTACH, {24'h00_0001, 2'b00, att_q[i]});
    rd(ped_pkg::REG_ATT_LO, 32'h0060_1303);
    cop(OP_EN);
    rd(ped_pkg::REG_STATUS, 32'h0000_0001);
    // Rising edge runs; falling edge must wait its turn
    ctx_in <= ped_pkg::ped_ctx_type'({11{16'hA5C3}});
    edge_input <= 4'b0001;
    wait_hi(1'b0);
    `CHK("evt", 6'h00, handler_evt)
    edge_input <= 4'b0000;
    no_start(12);
    ctx_in <= ped_pkg::ped_ctx_type'({11{16'h3C5A}});
    cop(OP_DIS);
    cop(10'h002);
    rd(ped_pkg::REG_STATUS, 32'h0000_0063);
    `CHK("invalid", 1'b1, invalid_op)
    cop(10'h001);
    fin(OP_LAST);
    `CHK("ctx", ped_pkg::ped_ctx_type'({11{16'hA5C3}}), ctx_out)
    wait_hi(1'b0);
    `CHK("evt", 6'h01, handler_evt)
    fin(OP_CRET);
    // A move in progress holds dispatch back
    lvl = 10'h004;
    cop(10'h000);
    spulse(26'h010_0000);
    no_start(10);
    lvl = 10'h000;
    cop(10'h000);
    wait_hi(1'b0);
    `CHK("evt", 6'h0C, handler_evt)
    fin(OP_LAST);
    // Queued while disabled, served comm first, then arrival order
    cop(OP_DIS);
    spulse(26'h010_0000);
    spulse(26'h000_0010);
    spulse(26'h000_0004);
    no_start(10);
    cop(OP_EN);
    foreach (ord_q[i])
    begin
      wait_hi(1'b0);
      `CHK("evt", ord_q[i], handler_evt)
      fin(OP_LAST);
    end
    // Timer a in delay mode matches; timer b without the mode stays quiet
    mt_delay_mode <= 2'b01;
    mt_preset     <= {16'h0007, 16'h0005};
    mt_current    <= {16'h0006, 16'h0004};
    no_start(20);
    mt_current    <= {16'h0007, 16'h0005};
    wait_hi(1'b0);
    `CHK("evt", 6'h15, handler_evt)
    fin(OP_LAST);
    no_start(30);
    // Re-attach restarts timing; a later period write is not picked up
    apb(1'b1, ped_pkg::REG_PER0, 32'h0000_0004);
    apb(1'b1, ped_pkg::REG_ATTACH, 32'h0000_010A);
    repeat (19) @(posedge clk);
    apb(1'b1, ped_pkg::REG_PER0, 32'h0000_0003);
    apb(1'b1, ped_pkg::REG_ATTACH, 32'h0000_010A);
    apb(1'b1, ped_pkg::REG_PER0, 32'h0000_0005);
    no_start(17);
    wait_hi(1'b0);
    t0 = cyc;
    `CHK("evt", 6'h0A, handler_evt)
    fin(OP_LAST);
    wait_hi(1'b0);
    `CHK("period", 3 * MS, cyc - t0)
    fin(OP_LAST);
    // Timed expiry while disabled waits behind a pulse-train event; run exit stops the timer
    apb(1'b1, ped_pkg::REG_ATTACH, 32'h0000_0113);
    cop(OP_DIS);
    spulse(26'h000_0040);
    no_start(35);
    apb(1'b1, ped_pkg::REG_CTRL, 32'h0000_0000);
    rd(ped_pkg::REG_ATT_LO, 32'h0068_1303);
    cop(OP_EN);
    wait_hi(1'b0);
    `CHK("evt", 6'h13, handler_evt)
    fin(OP_LAST);
    wait_hi(1'b0);
    `CHK("evt", 6'h0A, handler_evt)
    fin(OP_LAST);
    apb(1'b1, ped_pkg::REG_ATTACH, 32'h0000_000A);
    no_start(45);
    print_verdict();
  end
endmodule
`default_nettype wire
